// File: logic/qcia_agg.sv
// Queued completion tracker, DMA buffer steering and interrupt aggregation
`default_nettype none
// Functional notes
// RULE1: Set Device Bits with I bit clears every shadow bit set in its field.
// RULE2: Device sends DMA Setup naming the tag before that tag's data.
// RULE3: DMA Setup loads the DMA engine with that buffer's descriptor pointer.
// RULE4: Following data frames go to the selected buffer until the transfer ends.
// RULE5: Device reports completion with I bit and only its own tag bit; the bench's device reports tags 3 and 31 together in one frame.
// RULE6: Completion while interrupt pending clears tag, no extra interrupt.
// RULE7: Completion after software reset of pending flag raises new interrupt.
// RULE8: Software reset clears pending flag until next qualifying completion.
// RULE9: Service retires all tags whose shadow bit is clear, together.
// RULE10: Any Set Device Bits with I bit sets pending; output follows it.
module qcia_agg
  import qcia_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  input  wire logic                    ce,
  // Software command side
  input  wire logic                    issue_vld,
  input  wire logic [qcia_pkg::TAG_W-1:0] issue_tag,
  input  wire logic [qcia_pkg::PRD_W-1:0] issue_prd,
  input  wire logic                    irq_ack,
  input  wire logic                    retire_req,
  // Received frames
  input  wire logic                    sdb_vld,
  input  wire logic                    sdb_ibit,
  input  wire logic [31:0]             sdb_sact,
  input  wire logic                    dsetup_vld,
  input  wire logic [qcia_pkg::TAG_W-1:0] dsetup_buf,
  input  wire logic                    data_vld,
  input  wire logic [qcia_pkg::DATA_W-1:0] data_in,
  input  wire logic                    xfer_done,
  // DMA engine
  output logic                         dma_vld,
  output logic [qcia_pkg::PRD_W-1:0]   dma_prd,
  output logic [qcia_pkg::DATA_W-1:0]  dma_data,
  output logic                         dma_busy,
  // Status
  output logic [31:0]                  sact_shadow,
  output logic [31:0]                  retired,
  output logic                         retire_vld,
  output logic                         irq
);
  qcia_prd_if prd ();

  // Registered table read: the pointer is ready one cycle after the buffer is named
  qcia_prd_mem u_mem (
    .mclk (mclk),
    .ce   (ce),
    .prd  (prd)
  );

  typedef struct packed {
    logic [31:0]        sact;
    logic [31:0]        outst;
    logic               ipend;
    qcia_dma_st_t       st;
    logic [PRD_W-1:0]   prd;
    logic [DATA_W-1:0]  data;
    logic               dvld;
    logic [31:0]        ret;
    logic               rvld;
  } qcia_state_t;

  qcia_state_t s_r;
  qcia_state_t s_nxt;

  logic sdb_hit;
  assign sdb_hit = sdb_vld && sdb_ibit;

  assign prd.wr_en  = issue_vld;
  assign prd.wr_tag = issue_tag;
  assign prd.wr_ptr = issue_prd;
  assign prd.rd_tag = dsetup_buf;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.dvld = 1'b0;
    s_nxt.rvld = 1'b0;
    if (issue_vld) begin
      s_nxt.sact[issue_tag]  = 1'b1;
      s_nxt.outst[issue_tag] = 1'b1;
    end
    if (sdb_hit) begin
      s_nxt.sact = s_nxt.sact & ~sdb_sact; // RULE1
    end
    // Set beats clear so a completion racing the acknowledge is not lost
    if (sdb_hit) begin
      s_nxt.ipend = 1'b1; // RULE6 RULE7 RULE10
    end else if (irq_ack) begin
      s_nxt.ipend = 1'b0; // RULE8
    end
    if (retire_req) begin
      s_nxt.ret   = s_r.outst & ~s_r.sact; // RULE9
      s_nxt.outst = s_nxt.outst & s_r.sact;
      if (issue_vld) begin
        s_nxt.outst[issue_tag] = 1'b1;
      end
      s_nxt.rvld  = 1'b1;
    end
    unique case (s_r.st)
      QCIA_IDLE: begin
        if (dsetup_vld) begin
          s_nxt.st = QCIA_LOAD;
        end
      end
      QCIA_LOAD: begin
        // Table read was launched at the edge that took the DMA Setup
        s_nxt.prd = prd.rd_ptr; // RULE3
        s_nxt.st  = QCIA_XFER;
      end
      QCIA_XFER: begin
        if (data_vld) begin
          s_nxt.data = data_in; // RULE4
          s_nxt.dvld = 1'b1;
        end
        if (xfer_done) begin
          s_nxt.st = QCIA_IDLE;
        end
      end
      default: s_nxt.st = QCIA_IDLE;
    endcase
  end

  // The descriptor table is not reset; only this state word is
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r       <= '0;
      s_r.sact  <= SACT_RST;
      s_r.ipend <= IPEND_RST;
      s_r.st    <= QCIA_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Every output except dma_busy comes straight from a flip-flop of the state word; dma_busy decodes the state
  assign dma_vld     = s_r.dvld;
  assign dma_prd     = s_r.prd;
  assign dma_data    = s_r.data;
  assign dma_busy    = (s_r.st != QCIA_IDLE);
  assign sact_shadow = s_r.sact;
  assign retired     = s_r.ret;
  assign retire_vld  = s_r.rvld;
  assign irq         = s_r.ipend; // RULE10

  // Interrupt flag, shadow clearing, descriptor load, data steering and retirement
  a_sdb_clears: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
    ce && sdb_hit && !issue_vld |=> (sact_shadow & $past(sdb_sact)) == 32'h0)
    else $error("shadow bit not cleared");
  a_irq_raise: assert property (@(posedge mclk) disable iff (!arst_n) // RULE7
    ce && sdb_hit |=> irq)
    else $error("completion did not raise interrupt");
  a_irq_hold: assert property (@(posedge mclk) disable iff (!arst_n) // RULE6
    irq && !(ce && irq_ack) |=> irq)
    else $error("pending flag dropped without reset");
  a_ack_clears: assert property (@(posedge mclk) disable iff (!arst_n) // RULE8
    ce && irq_ack && !sdb_hit |=> !irq)
    else $error("reset of pending flag ignored");
  a_no_spur_irq: assert property (@(posedge mclk) disable iff (!arst_n) // RULE10
    !irq && !(ce && sdb_hit) |=> !irq)
    else $error("interrupt without completion");
  a_load_ptr: assert property (@(posedge mclk) disable iff (!arst_n) // RULE3
    ce && dsetup_vld && !dma_busy ##1 ce |=> dma_busy && dma_prd == $past(prd.rd_ptr))
    else $error("descriptor pointer not loaded");
  a_data_steer: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
    ce && s_r.st == QCIA_XFER && data_vld |=> dma_vld && dma_data == $past(data_in))
    else $error("data frame not forwarded");
  a_retire_set: assert property (@(posedge mclk) disable iff (!arst_n) // RULE9
    ce && retire_req |=> retire_vld && (retired & sact_shadow & ~$past(sdb_sact)) == 32'h0)
    else $error("retired a still active tag");

  // Strobes and the selected buffer, checked against the transfer state
  a_dvld_pulse: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
    ce && !(data_vld && s_r.st == QCIA_XFER) |=> !dma_vld)
    else $error("data strobe without a data frame");
  a_buf_stable: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
    ce && s_r.st == QCIA_XFER && !xfer_done |=> dma_busy && $stable(dma_prd))
    else $error("buffer changed during a transfer");
  a_xfer_end: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
    ce && s_r.st == QCIA_XFER && xfer_done |=> !dma_busy)
    else $error("transfer did not end");
  a_setup_busy: assert property (@(posedge mclk) disable iff (!arst_n) // RULE3
    ce && dsetup_vld && !dma_busy |=> dma_busy)
    else $error("buffer selection did not start the engine");
  a_idle_stay: assert property (@(posedge mclk) disable iff (!arst_n) // RULE3
    ce && !dma_busy && !dsetup_vld |=> !dma_busy)
    else $error("engine started without a buffer selection");

  // Shadow register and retirement
  a_sdb_exact: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
    ce && sdb_hit && !issue_vld |=> sact_shadow == ($past(sact_shadow) & ~$past(sdb_sact)))
    else $error("shadow bits outside the field changed");
  a_no_ibit: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
    ce && sdb_vld && !sdb_ibit && !issue_vld |=> $stable(sact_shadow))
    else $error("frame without I bit changed the shadow");
  a_retire_pulse: assert property (@(posedge mclk) disable iff (!arst_n) // RULE9
    ce && !retire_req |=> !retire_vld)
    else $error("retire strobe without a request");
  a_retire_keep: assert property (@(posedge mclk) disable iff (!arst_n) // RULE9
    ce && !retire_req |=> $stable(retired))
    else $error("retired set changed without a request");
  // A frozen engine must hold every output, or a stalled host would lose completions
  a_state_frozen: assert property (@(posedge mclk) disable iff (!arst_n) // RULE10
    !ce |=> $stable(irq) && $stable(sact_shadow) && $stable(dma_busy) && $stable(retired))
    else $error("state moved while clock enable was low");

  // One pair per tag, so a wrong bit index cannot hide behind the other tags
  for (genvar g = 0; g < NTAGS; g++) begin : g_tag
    a_tag_clear: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
      ce && sdb_hit && sdb_sact[g] |=> !sact_shadow[g])
      else $error("tag bit survived its completion");
    a_tag_keep: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
      ce && !(issue_vld && issue_tag == TAG_W'(g)) && !(sdb_hit && sdb_sact[g]) |=> $stable(sact_shadow[g]))
      else $error("tag bit changed without cause");
  end
endmodule : qcia_agg
`default_nettype wire

// File: common/qcia_pkg.sv
// Package with constants and types for queued completion interrupt aggregation
`default_nettype none
package qcia_pkg;
  localparam int unsigned TAG_W      = 5;
  localparam int unsigned NTAGS      = 32;
  localparam int unsigned PRD_W      = 32;
  localparam int unsigned DATA_W     = 32;
  localparam logic [31:0] SACT_RST   = 32'h0000_0000;
  localparam logic        IPEND_RST  = 1'b0;
  typedef enum logic [1:0] {
    QCIA_IDLE = 2'b00,
    QCIA_LOAD = 2'b01,
    QCIA_XFER = 2'b11
  } qcia_dma_st_t;
endpackage : qcia_pkg
`default_nettype wire

// File: common/qcia_prd_if.sv
// Interface between the aggregator and its descriptor table
`default_nettype none
interface qcia_prd_if;
  import qcia_pkg::*;
  logic             wr_en;
  logic [TAG_W-1:0] wr_tag;
  logic [PRD_W-1:0] wr_ptr;
  logic [TAG_W-1:0] rd_tag;
  logic [PRD_W-1:0] rd_ptr;
  modport table_side (input wr_en, input wr_tag, input wr_ptr, input rd_tag, output rd_ptr);
  modport user_side  (output wr_en, output wr_tag, output wr_ptr, output rd_tag, input rd_ptr);
endinterface : qcia_prd_if
`default_nettype wire

// File: logic/qcia_prd_mem.sv
// Per-tag descriptor pointer table with registered read data
`default_nettype none
module qcia_prd_mem
  import qcia_pkg::*;
(
  // Clocking
  input  wire logic   mclk,
  input  wire logic   ce,
  // Access
  qcia_prd_if.table_side prd
);
  logic [PRD_W-1:0] mem [NTAGS];

  // No reset on the array; contents are written by each issue command
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (prd.wr_en) begin
        mem[prd.wr_tag] <= prd.wr_ptr;
      end
      prd.rd_ptr <= mem[prd.rd_tag];
    end
  end
endmodule : qcia_prd_mem
`default_nettype wire

// File: sim/qcia_dev.sv
// Device model that serves queued reads and reports completions
`default_nettype none
module qcia_dev (
  // Clock
  input  wire logic        mclk,
  // Frames to host
  output logic             dsetup_vld,
  output logic [4:0]       dsetup_buf,
  output logic             data_vld,
  output logic [31:0]      data_in,
  output logic             xfer_done,
  output logic             sdb_vld,
  output logic             sdb_ibit,
  output logic [31:0]      sdb_sact
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {dsetup_vld, dsetup_buf, data_vld, data_in, xfer_done, sdb_vld, sdb_ibit, sdb_sact} = '0;
  // Released lines show the inverse so stale data is never mistaken for valid
  task automatic serve(input logic [4:0] t, input logic [31:0] w, input int n);
    @(posedge mclk) {dsetup_vld, dsetup_buf} <= {1'b1, t};
    @(posedge mclk) {dsetup_vld, dsetup_buf} <= {1'b0, ~t};
    for (int i = 0; i < n; i++) begin
      @(posedge mclk) {data_vld, data_in} <= {1'b1, w + 32'(i)};
    end
    @(posedge mclk) {data_vld, xfer_done, data_in} <= {2'b01, ~data_in};
    @(posedge mclk) xfer_done <= 1'b0;
  endtask : serve
  task automatic sdb(input logic [31:0] s, input logic ib);
    @(posedge mclk) {sdb_vld, sdb_ibit, sdb_sact} <= {1'b1, ib, s};
    @(posedge mclk) {sdb_vld, sdb_ibit, sdb_sact} <= {1'b0, ~ib, ~s};
  endtask : sdb
endmodule : qcia_dev
`default_nettype wire

// File: sim/qcia_agg_tb.sv
// Self-checking bench for the completion aggregator
`default_nettype none
module qcia_agg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, arst_n, issue_vld, irq_ack, retire_req, dsetup_vld, data_vld, xfer_done, sdb_vld, sdb_ibit;
  logic dma_vld, dma_busy, retire_vld, irq;
  logic [4:0] issue_tag, dsetup_buf;
  logic [31:0] issue_prd, sdb_sact, data_in, dma_prd, dma_data, sact_shadow, retired, p0, p5;
  logic [15:0] lf = 16'hec54;
  logic [63:0] dma_q[$];
  logic [31:0] ret_q[$];
  logic ce = 1'b1;
  int err_total, cmp_count, cyc;
  qcia_agg qcia_agg_inst (.mclk(mclk), .arst_n(arst_n), .ce(ce), .issue_vld(issue_vld), .issue_tag(issue_tag),
    .issue_prd(issue_prd), .irq_ack(irq_ack), .retire_req(retire_req), .sdb_vld(sdb_vld), .sdb_ibit(sdb_ibit),
    .sdb_sact(sdb_sact), .dsetup_vld(dsetup_vld), .dsetup_buf(dsetup_buf), .data_vld(data_vld), .data_in(data_in),
    .xfer_done(xfer_done), .dma_vld(dma_vld), .dma_prd(dma_prd), .dma_data(dma_data), .dma_busy(dma_busy),
    .sact_shadow(sact_shadow), .retired(retired), .retire_vld(retire_vld), .irq(irq));
  qcia_dev qcia_dev_inst (.mclk(mclk), .dsetup_vld(dsetup_vld), .dsetup_buf(dsetup_buf), .data_vld(data_vld),
    .data_in(data_in), .xfer_done(xfer_done), .sdb_vld(sdb_vld), .sdb_ibit(sdb_ibit), .sdb_sact(sdb_sact));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk_dma(input logic [64:0] e, input logic [64:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("Error dma expected %h seen %h", e, s);
    end
  endtask : chk_dma
  task automatic chk_ret(input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("Error retired expected %h seen %h", e, s);
    end
  endtask : chk_ret
  task automatic chk_stat(input logic [33:0] e, input logic [33:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("Error busy_irq_shadow expected %h seen %h", e, s);
    end
  endtask : chk_stat
  task automatic test_done;
    // Results that never appeared count as mismatches
    if (dma_q.size() != 0 || ret_q.size() != 0) err_total++;
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic issue(input logic [4:0] t, input logic [31:0] p);
    @(posedge mclk) {issue_vld, issue_tag, issue_prd} <= {1'b1, t, p};
    @(posedge mclk) {issue_vld, issue_tag, issue_prd} <= {1'b0, ~t, ~p};
  endtask : issue
  // Software pulse: 2 resets the pending flag, 1 asks for retirement
  task automatic sw(input logic [1:0] k);
    @(posedge mclk) {irq_ack, retire_req} <= k;
    @(posedge mclk) {irq_ack, retire_req} <= 2'b00;
  endtask : sw
  task automatic xfer(input logic [4:0] t, input logic [31:0] p, input int n);
    lf = lfsr(lf);
    for (int i = 0; i < n; i++) dma_q.push_back({p, {~lf, lf} + 32'(i)});
    qcia_dev_inst.serve(t, {~lf, lf}, n);
  endtask : xfer
  task automatic stat(input logic ir, input logic [31:0] sh);
    #1 chk_stat({1'b0, ir, sh}, {dma_busy, irq, sact_shadow});
  endtask : stat
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (dma_vld) chk_dma({1'b1, dma_q.size() != 0 ? dma_q.pop_front() : 64'hx},
                         {dma_busy, dma_prd, dma_data});
    if (retire_vld) chk_ret(ret_q.size() != 0 ? ret_q.pop_front() : 32'hx, retired);
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      test_done;
    end
  end
  initial begin
    {mclk, arst_n, issue_vld, issue_tag, issue_prd, irq_ack, retire_req} = '0;
    lf = lfsr(lf);
    p0 = {lf, ~lf};
    lf = lfsr(lf);
    p5 = {~lf, lf};
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    issue(5'h00, p0);
    issue(5'h05, p5);
    stat(1'b0, 32'h21);
    // Second issued command is served first
    xfer(5'h05, p5, 3);
    qcia_dev_inst.sdb(32'h20, 1'b1);
    stat(1'b1, 32'h01);
    xfer(5'h00, p0, 2);
    qcia_dev_inst.sdb(32'h01, 1'b1);
    stat(1'b1, 32'h00);
    // Clock enable low: the acknowledge must be ignored and the flag held
    @(posedge mclk) ce <= 1'b0;
    sw(2'b10);
    stat(1'b1, 32'h00);
    @(posedge mclk) ce <= 1'b1;
    sw(2'b10);
    repeat (3) @(posedge mclk);
    stat(1'b0, 32'h00);
    ret_q.push_back(32'h21);
    sw(2'b01);
    issue(5'h1f, p0);
    issue(5'h03, p5);
    qcia_dev_inst.sdb(32'h8000_0008, 1'b0);
    stat(1'b0, 32'h8000_0008);
    qcia_dev_inst.sdb(32'h8000_0008, 1'b1);
    stat(1'b1, 32'h00);
    sw(2'b10);
    ret_q.push_back(32'h8000_0008);
    sw(2'b01);
    repeat (3) @(posedge mclk);
    issue(5'h07, p0);
    // Mid-run reset must clear the shadow and the retired set at once
    arst_n <= 1'b0;
    #1 chk_stat(34'h0, {dma_busy, irq, sact_shadow});
    chk_ret(32'h0, retired);
    @(posedge mclk) arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    test_done;
  end
endmodule : qcia_agg_tb
`default_nettype wire
